// *** core/rscu_core.sv ***
// Execution of stack drop, stack push, relative call and software reset.
`timescale 1ns/1ps
`default_nettype none
module rscu_core
    import rscu_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire rscu_instr_t instr,
    input wire logic status_we,
    input wire logic [7:0] status_in,
    output rscu_view_t view
);
    rscu_state_t state_q, state_d;
    logic [RSCU_PC_W-1:0] pc_q, pc_d;
    logic [RSCU_PC_W-1:0] stack_q [RSCU_DEPTH];
    logic [RSCU_PC_W-1:0] stack_d [RSCU_DEPTH];
    logic [RSCU_PTR_W-1:0] depth_q, depth_d;
    logic [7:0] status_q, status_d;
    logic swrst_q, swrst_d;
    logic is_drop, is_push, is_call, is_swrst, take;
    logic [RSCU_PC_W-1:0] ret_addr, call_tgt, ofs_ext;
    rscu_view_t view_d;

    assign take = instr.valid && state_q == RSCU_EXEC;
    assign is_drop = take && instr.word == RSCU_OP_DROP;
    assign is_push = take && instr.word == RSCU_OP_PUSH;
    assign is_swrst = take && instr.word == RSCU_OP_SWRST;
    assign is_call = take && instr.word[15:RSCU_CALL_TOP_LSB] == RSCU_CALL_TOP;
    assign ofs_ext = RSCU_PC_W'({{(RSCU_PC_W-RSCU_OFS_W){instr.word[RSCU_OFS_W-1]}},
        instr.word[RSCU_OFS_W-1:0]});
    assign ret_addr = pc_q + RSCU_PC_STEP;
    assign call_tgt = ret_addr + (ofs_ext << 1);

    always_comb begin
        state_d = state_q;
        pc_d = pc_q;
        depth_d = depth_q;
        status_d = status_we ? status_in : status_q;
        swrst_d = 1'b0;
        for (int i = 0; i < RSCU_DEPTH; i++) begin
            stack_d[i] = stack_q[i];
        end
        case (state_q)
            RSCU_EXEC: begin
                if (take) begin
                    pc_d = ret_addr;
                end
                if (is_swrst) begin
                    // Routed through a pulse so the same reset path clears all internal state; the view register is left to follow it.
                    // The word taken in the next cycle is lost, as the clear lands on that edge.
                    swrst_d = 1'b1;
                end else if (is_drop) begin
                    // Entries shift up; an empty stack stays empty.
                    for (int i = 0; i < RSCU_DEPTH - 1; i++) begin
                        stack_d[i] = stack_q[i+1];
                    end
                    stack_d[RSCU_DEPTH-1] = RSCU_PC_RST;
                    if (depth_q != RSCU_PTR_RST) begin
                        depth_d = depth_q - 5'h01;
                    end
                    status_d = status_q;
                end else if (is_push || is_call) begin
                    for (int i = 1; i < RSCU_DEPTH; i++) begin
                        stack_d[i] = stack_q[i-1];
                    end
                    stack_d[0] = ret_addr;
                    // A push onto a full stack loses the oldest entry without any warning.
                    if (depth_q != RSCU_PTR_W'(RSCU_DEPTH)) begin
                        depth_d = depth_q + 5'h01;
                    end
                    status_d = status_q;
                    if (is_call) begin
                        pc_d = call_tgt;
                        state_d = RSCU_IDLE2;
                    end
                end
            end
            RSCU_IDLE2: begin
                // A word offered here is ignored, so the caller must leave this cycle empty.
                state_d = RSCU_EXEC;
            end
            default: begin
                state_d = RSCU_EXEC;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset || swrst_q) begin
            state_q <= RSCU_EXEC;
            pc_q <= RSCU_PC_RST;
            depth_q <= RSCU_PTR_RST;
            status_q <= RSCU_STATUS_RST;
            swrst_q <= 1'b0;
            for (int i = 0; i < RSCU_DEPTH; i++) begin
                stack_q[i] <= RSCU_PC_RST;
            end
        end else if (clk_en) begin
            state_q <= state_d;
            pc_q <= pc_d;
            depth_q <= depth_d;
            status_q <= status_d;
            swrst_q <= swrst_d;
            for (int i = 0; i < RSCU_DEPTH; i++) begin
                stack_q[i] <= stack_d[i];
            end
        end
    end

    // Outputs are registered copies of internal state, so they trail it by one cycle.
    always_comb begin
        view_d.pc = pc_q;
        view_d.top_of_stack_entry = stack_q[0];
        view_d.depth = depth_q;
        view_d.status = status_q;
        view_d.soft_reset = swrst_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            view <= '0;
        end else begin
            view <= view_d;
        end
    end

    // Stack checks look one edge ahead; a software reset in flight takes that edge instead.
    drop_top_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && is_drop && !swrst_q |=> stack_q[0] == $past(stack_q[1]))
        else $error("Drop did not expose entry below.");

    drop_keep_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && is_drop && !swrst_q |=> stack_q[1] == $past(stack_q[2]))
        else $error("Drop did not move deeper entries up.");

    drop_depth_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && is_drop && !swrst_q && depth_q != RSCU_PTR_RST
        |=> depth_q == $past(depth_q) - 5'h01)
        else $error("Drop did not lower the depth.");

    push_top_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && is_push && !swrst_q |=> stack_q[0] == $past(pc_q) + RSCU_PC_STEP)
        else $error("Push wrote wrong address.");

    push_keep_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && is_push && !swrst_q |=> stack_q[1] == $past(stack_q[0]))
        else $error("Push lost previous top.");

    push_depth_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && is_push && !swrst_q && depth_q != RSCU_PTR_W'(RSCU_DEPTH)
        |=> depth_q == $past(depth_q) + 5'h01)
        else $error("Push did not raise the depth.");

    call_decode_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && take && !swrst_q && instr.word[15:RSCU_CALL_TOP_LSB] == RSCU_CALL_TOP
        |=> state_q == RSCU_IDLE2)
        else $error("Call not decoded.");

    call_only_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && take && instr.word[15:RSCU_CALL_TOP_LSB] != RSCU_CALL_TOP
        |=> state_q == RSCU_EXEC)
        else $error("Non-call word entered the idle cycle.");

    call_target_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && is_call && !swrst_q
        |=> pc_q == $past(pc_q) + RSCU_PC_STEP
            + {{(RSCU_PC_W-RSCU_OFS_W-1){$past(instr.word[RSCU_OFS_W-1])}},
            $past(instr.word[RSCU_OFS_W-1:0]), 1'b0} && state_q == RSCU_IDLE2)
        else $error("Call target wrong.");

    call_idle_a: assert property (@(posedge clk) disable iff (reset)
        state_q == RSCU_IDLE2 && clk_en
        |=> state_q == RSCU_EXEC && $stable(pc_q) && $stable(depth_q))
        else $error("Second call cycle did work.");

    call_ret_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && is_call && !swrst_q |=> stack_q[0] == $past(pc_q) + RSCU_PC_STEP)
        else $error("Call pushed wrong return.");

    call_keep_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && is_call && !swrst_q |=> stack_q[1] == $past(stack_q[0]))
        else $error("Call lost previous top.");

    flags_keep_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && (is_call || is_push || is_drop) && !swrst_q |=> $stable(status_q))
        else $error("Flags changed.");

    soft_reset_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && is_swrst |=> ##1 pc_q == RSCU_PC_RST && depth_q == RSCU_PTR_RST)
        else $error("Software reset incomplete.");

    soft_clear_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && is_swrst && !swrst_q |=> ##1 stack_q[0] == RSCU_PC_RST
            && status_q == RSCU_STATUS_RST && state_q == RSCU_EXEC)
        else $error("Software reset left stack, flags or state.");

    soft_pulse_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && is_swrst && !swrst_q |=> swrst_q ##1 !swrst_q)
        else $error("Software reset pulse wrong.");

    pc_step_a: assert property (@(posedge clk) disable iff (reset)
        clk_en && take && !is_call && !is_swrst && !swrst_q
        |=> pc_q == $past(pc_q) + RSCU_PC_STEP)
        else $error("PC did not step by two.");

    call_seen_c: cover property (@(posedge clk) clk_en && is_call);
    push_drop_c: cover property (@(posedge clk) is_push ##1 is_drop);
    swrst_seen_c: cover property (@(posedge clk) clk_en && is_swrst);
    call_chain_c: cover property (@(posedge clk) (clk_en && is_call) ##2 (clk_en && is_call));
    frozen_offer_c: cover property (@(posedge clk) !clk_en && instr.valid);
endmodule // rscu_core
`default_nettype wire

// *** core/rscu_pkg.sv ***
// Package for the return stack and relative call unit.
`default_nettype none
package rscu_pkg;
    localparam int RSCU_PC_W = 21;
    localparam int RSCU_DEPTH = 31;
    localparam int RSCU_PTR_W = 5;
    localparam logic [15:0] RSCU_OP_DROP = 16'h0006;
    localparam logic [15:0] RSCU_OP_PUSH = 16'h0005;
    localparam logic [15:0] RSCU_OP_SWRST = 16'h00ff;
    localparam logic [4:0] RSCU_CALL_TOP = 5'h1b;
    localparam int RSCU_CALL_TOP_LSB = 11;
    localparam int RSCU_OFS_W = 11;
    localparam logic [RSCU_PC_W-1:0] RSCU_PC_STEP = 21'h00_0002;
    localparam logic [RSCU_PC_W-1:0] RSCU_PC_RST = 21'h00_0000;
    localparam logic [RSCU_PTR_W-1:0] RSCU_PTR_RST = 5'h00;
    localparam logic [7:0] RSCU_STATUS_RST = 8'h00;

    typedef enum logic [1:0] {
        RSCU_EXEC = 2'b01,
        RSCU_IDLE2 = 2'b10
    } rscu_state_t;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } rscu_instr_t;

    typedef struct packed {
        logic [RSCU_PC_W-1:0] pc;
        logic [RSCU_PC_W-1:0] top_of_stack_entry;
        logic [RSCU_PTR_W-1:0] depth;
        logic [7:0] status;
        logic soft_reset;
    } rscu_view_t;
endpackage : rscu_pkg
`default_nettype wire

// *** verification/return_stack_call_unit_tb.sv ***
// Self-checking testbench for the return stack and relative call unit.
`timescale 1ns/1ps
`default_nettype none
module return_stack_call_unit_tb;
    import rscu_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    rscu_instr_t instr = '0;
    logic status_we = 1'b0;
    logic [7:0] status_in = 8'h00;
    rscu_view_t view;
    int error_cnt = 0;
    int n_compared = 0;
    rscu_core i_rscu_core (.clk(clk), .reset(reset), .clk_en(clk_en), .instr(instr),
        .status_we(status_we), .status_in(status_in), .view(view));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [20:0] seen, input logic [20:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask
    // Inputs change only at the falling edge; each call spans one rising edge.
    task automatic step(input logic v, input logic [15:0] w);
        instr = '{valid: v, word: w};
        @(negedge clk);
    endtask
    task automatic test_push_drop();
        status_we = 1'b1;
        status_in = 8'h5a;
        step(1'b0, 16'h0000);
        // Flag writes that collide with push or drop must be dropped.
        status_in = 8'ha5;
        step(1'b1, RSCU_OP_PUSH);
        step(1'b1, RSCU_OP_PUSH);
        status_we = 1'b0;
        step(1'b0, 16'h0000);
        step(1'b0, 16'h0000);
        chk(view.pc, 21'h00_0004, "pc after pushes");
        chk(view.top_of_stack_entry, 21'h00_0004, "top after pushes");
        chk(21'(view.depth), 21'h00_0002, "depth after pushes");
        chk(21'(view.status), 21'h00_005a, "flags after pushes");
        status_we = 1'b1;
        step(1'b1, RSCU_OP_DROP);
        status_we = 1'b0;
        step(1'b0, 16'h0000);
        step(1'b0, 16'h0000);
        chk(view.top_of_stack_entry, 21'h00_0002, "top after drop");
        chk(21'(view.status), 21'h00_005a, "flags after drop");
        chk(21'(view.depth), 21'h00_0001, "depth after drop");
        chk(view.pc, 21'h00_0006, "pc after drop");
        $display("test push_drop done");
    endtask
    task automatic test_call();
        clk_en = 1'b0;
        step(1'b1, RSCU_OP_PUSH);
        clk_en = 1'b1;
        step(1'b0, 16'h0000);
        step(1'b0, 16'h0000);
        chk(21'(view.depth), 21'h00_0001, "frozen push");
        status_we = 1'b1;
        step(1'b1, 16'hdffd);
        status_we = 1'b0;
        step(1'b0, 16'h0000);
        step(1'b0, 16'h0000);
        chk(view.pc, 21'h00_0002, "pc after back call");
        chk(view.top_of_stack_entry, 21'h00_0008, "return after back call");
        chk(21'(view.depth), 21'h00_0002, "depth after call");
        // Offset extremes, each call followed by at least one empty cycle.
        step(1'b1, 16'hdbff);
        step(1'b0, 16'h0000);
        step(1'b1, 16'hdc00);
        step(1'b0, 16'h0000);
        step(1'b0, 16'h0000);
        chk(view.pc, 21'h00_0004, "pc after extreme calls");
        chk(view.top_of_stack_entry, 21'h00_0804, "return after extreme calls");
        chk(21'(view.depth), 21'h00_0004, "depth after calls");
        chk(21'(view.status), 21'h00_005a, "flags after calls");
        $display("test call done");
    endtask
    task automatic test_swrst();
        step(1'b1, RSCU_OP_SWRST);
        step(1'b0, 16'h0000);
        // The pulse shows for one cycle, one edge ahead of the cleared state.
        chk(21'(view.soft_reset), 21'h00_0001, "soft reset flag");
        step(1'b0, 16'h0000);
        chk(21'(view.soft_reset), 21'h00_0000, "soft reset pulse ends");
        chk(view.pc, 21'h00_0000, "pc after soft reset");
        chk(view.top_of_stack_entry, 21'h00_0000, "top after soft reset");
        chk(21'(view.depth), 21'h00_0000, "depth after soft reset");
        chk(21'(view.status), 21'h00_0000, "flags after soft reset");
        step(1'b1, 16'h0000);
        step(1'b0, 16'h0000);
        step(1'b0, 16'h0000);
        chk(view.pc, 21'h00_0002, "pc after plain word");
        $display("test swrst done");
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (6) @(negedge clk);
        reset = 1'b0;
        test_push_drop();
        test_call();
        test_swrst();
        end_of_test();
    end
endmodule // return_stack_call_unit_tb
`default_nettype wire
